// File: rtu_master_model.sv
// bus master model: sends request frames, collects reply bytes
`timescale 1ns/10ps
module rtu_master_model #(
  parameter int GAP = 20
) (
  // clock
  input  wire logic       i_mclk,
  // request stream into the slave
  output logic            o_rx_valid,
  output logic [7:0]      o_rx_data,
  output logic            o_rx_parity_err,
  // reply stream from the slave
  input  wire logic       i_tx_valid,
  input  wire logic [7:0] i_tx_data,
  output logic            o_tx_ready
);
  import rtu_pkg::*;
  logic [7:0] rxq [$];
  int         stall = 0;
  int         cyc   = 0;

  initial begin
    o_rx_valid      = 1'b0;
    o_rx_data       = 8'h00;
    o_rx_parity_err = 1'b0;
  end

  function automatic logic [15:0] crc16(input logic [7:0] b [$]);
    logic [15:0] c;
    c = CRC_INIT;
    foreach (b[i]) begin
      c = c ^ {8'h00, b[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction : crc16

  // bytes in caller order, crc low byte first
  task automatic send(input logic [7:0] b [$], input int perr_at, input int split_at,
                      input logic [15:0] crc_xor);
    logic [15:0] c;
    c = crc16(b) ^ crc_xor;
    b.push_back(c[7:0]);
    b.push_back(c[15:8]);
    foreach (b[i]) begin
      if (i == split_at) repeat (GAP + 10) @(posedge i_mclk);
      @(posedge i_mclk);
      o_rx_valid      <= 1'b1;
      o_rx_data       <= b[i];
      o_rx_parity_err <= (i == perr_at);
      @(posedge i_mclk);
      o_rx_valid      <= 1'b0;
      o_rx_data       <= ~b[i];
      o_rx_parity_err <= 1'b0;
    end
  endtask : send

  // reply collected, ready stalls on request
  always @(posedge i_mclk) begin
    if (i_tx_valid === 1'b1 && o_tx_ready) rxq.push_back(i_tx_data);
    o_tx_ready <= (stall == 0) || (cyc % (stall + 1) == 0);
    cyc        <= cyc + 1;
  end
endmodule : rtu_master_model

// File: rtu_pkg.sv
// constants and types for the rtu slave frame interpreter
// Functional notes
// - write reply echoes address, function, start, count
// - consecutive registers from start, count one allowed
// - ident reply fixed header then objects
// - three basic objects: vendor, product, revision
// - code 01 sequence, code 04 single object
// - object value raw ASCII, length equals characters
// - parity or CRC error gives no reply
// - gap of 3.5 characters or more ends frame
// - unknown function gives exception code 1
// - missing register gives exception code 2
// - bad value or read-only gives code 3
// - exception: address, function with MSB, code
// - 16-bit fields sent high byte first
// - frames over 64 bytes are invalid
// - reply starts 2 to 10 ms after request
package rtu_pkg;
  localparam logic [7:0]  FC_WRITE_MULTI = 8'h10;
  localparam logic [7:0]  FC_IDENT       = 8'h2B;
  localparam logic [7:0]  MEI_IDENT      = 8'h0E;
  localparam logic [7:0]  RD_BASIC       = 8'h01;
  localparam logic [7:0]  RD_SINGLE      = 8'h04;
  localparam logic [7:0]  CONFORMITY     = 8'h81;
  localparam logic [7:0]  NO_MORE        = 8'h00;
  localparam logic [7:0]  EXC_FLAG       = 8'h80;
  localparam logic [7:0]  EXC_FUNC       = 8'h01;
  localparam logic [7:0]  EXC_ADDR       = 8'h02;
  localparam logic [7:0]  EXC_VALUE      = 8'h03;
  localparam logic [7:0]  OBJ_LAST       = 8'h02;
  localparam logic [15:0] CRC_INIT       = 16'hFFFF;
  localparam logic [15:0] CRC_POLY       = 16'hA001;
  localparam int          FRAME_MAX      = 64;
  localparam int          FRAME_MIN      = 4;
  localparam int          WR_HDR_LEN     = 9;
  localparam int          WR_MAX_REGS    = 27;
  localparam int          IDENT_LEN      = 7;
  localparam int          EXC_LEN        = 3;
  localparam int          ECHO_LEN       = 6;
  localparam int          IDHDR_LEN      = 8;
  localparam int          NUM_REGS_DEF   = 1024;
  localparam int          FIFO_DEPTH     = 32;
  localparam longint      CLK_HZ         = 50_000_000;
  localparam longint      BAUD_DEF       = 19_200;
  localparam longint      CHAR_BITS      = 11;
  localparam longint      GAP_X10        = 35;
  localparam longint      RESP_MIN_US    = 2_000;
  localparam longint      RESP_MAX_US    = 10_000;
  // least times round up
  localparam longint      GAP_CYC_DEF    =
    (GAP_X10 * CHAR_BITS * CLK_HZ + 10 * BAUD_DEF - 1) / (10 * BAUD_DEF);
  localparam longint      RESP_CYC_DEF   =
    (RESP_MIN_US * CLK_HZ + 1_000_000 - 1) / 1_000_000;
  localparam longint      RESP_MAX_CYC   = RESP_MAX_US * CLK_HZ / 1_000_000;
  typedef enum logic [1:0] {RK_EXC, RK_ECHO, RK_IDENT} rtu_kind_t;
  typedef enum logic [3:0] {
    ST_RX, ST_CRC, ST_EVAL, ST_WCHK, ST_WR, ST_HDR,
    ST_OBJ, ST_WAIT, ST_SEND, ST_CRCLO, ST_CRCHI
  } rtu_state_t;
endpackage : rtu_pkg

// File: rtu_slave.sv
// rtu slave frame interpreter with transmit fifo
`timescale 1ns/10ps
module rtu_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 32
) (
  // clock and control
  input  wire logic         i_mclk,
  input  wire logic         i_reset,
  input  wire logic         i_ce,
  // fill side
  input  wire logic         i_valid,
  input  wire logic [W-1:0] i_data,
  output logic              o_ready,
  // drain side
  output logic              o_valid,
  output logic [W-1:0]      o_data,
  input  wire logic         i_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wptr;
  logic [AW:0]  rptr;
  logic [AW:0]  next_wptr;
  logic [AW:0]  next_rptr;
  logic         push;
  logic         pop;
  always_comb begin
    o_ready   = (wptr - rptr) != (AW+1)'(DEPTH);
    o_valid   = wptr != rptr;
    o_data    = mem[rptr[AW-1:0]];
    push      = i_valid && o_ready;
    pop       = o_valid && i_ready;
    next_wptr = push ? wptr + 1'b1 : wptr;
    next_rptr = pop ? rptr + 1'b1 : rptr;
  end
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      wptr <= '0;
      rptr <= '0;
    end else if (i_ce) begin
      wptr <= next_wptr;
      rptr <= next_rptr;
      if (push) begin
        mem[wptr[AW-1:0]] <= i_data;
      end
    end
  end
endmodule : rtu_fifo

module rtu_slave #(
  parameter int unsigned     NUM_REGS    = rtu_pkg::NUM_REGS_DEF,
  parameter int unsigned     GAP_CYC     = 32'(rtu_pkg::GAP_CYC_DEF),
  parameter int unsigned     RESP_CYC    = 32'(rtu_pkg::RESP_CYC_DEF),
  parameter int              VENDOR_LEN  = 4,
  parameter int              PRODUCT_LEN = 5,
  parameter int              REV_LEN     = 5,
  // identity strings, values arbitrary
  parameter logic [8*VENDOR_LEN-1:0]  VENDOR  = "VNDR",
  parameter logic [8*PRODUCT_LEN-1:0] PRODUCT = "DRV01",
  parameter logic [8*REV_LEN-1:0]     REVISION = "V3.21"
) (
  // clock and control
  input  wire logic        i_mclk,
  input  wire logic        i_reset,
  input  wire logic        i_ce,
  input  wire logic [7:0]  i_station_addr,
  // receive byte stream
  input  wire logic        i_rx_valid,
  input  wire logic [7:0]  i_rx_data,
  input  wire logic        i_rx_parity_err,
  // transmit byte stream
  output logic             o_tx_valid,
  output logic [7:0]       o_tx_data,
  input  wire logic        i_tx_ready,
  // parameter memory write port
  output logic             o_wr_en,
  output logic [15:0]      o_wr_addr,
  output logic [15:0]      o_wr_data,
  input  wire logic        i_wr_reject
);
  import rtu_pkg::*;
  localparam logic [23:0] GCNT_MAX = 24'hFF_FFFF;

  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crc_byte

  function automatic logic [7:0] obj_len(input logic [1:0] o);
    unique case (o)
      2'd0:    obj_len = 8'(VENDOR_LEN);
      2'd1:    obj_len = 8'(PRODUCT_LEN);
      default: obj_len = 8'(REV_LEN);
    endcase
  endfunction : obj_len

  function automatic logic [7:0] obj_chr(input logic [1:0] o, input logic [7:0] i);
    unique case (o)
      2'd0:    obj_chr = VENDOR[8*(VENDOR_LEN-1-int'(i)) +: 8];
      2'd1:    obj_chr = PRODUCT[8*(PRODUCT_LEN-1-int'(i)) +: 8];
      default: obj_chr = REVISION[8*(REV_LEN-1-int'(i)) +: 8];
    endcase
  endfunction : obj_chr

  logic [7:0]  rxb [FRAME_MAX];
  logic [7:0]  rbuf [FRAME_MAX];
  rtu_state_t  state, next_state;
  rtu_kind_t   kind, next_kind;
  logic [6:0]  len, next_len;
  logic        over, next_over;
  logic        perr, next_perr;
  logic [23:0] gcnt, next_gcnt;
  logic [6:0]  idx, next_idx;
  logic [15:0] crc, next_crc;
  logic [7:0]  exc, next_exc;
  logic [5:0]  k, next_k;
  logic        phase, next_phase;
  logic [6:0]  rlen, next_rlen;
  logic [1:0]  obj, next_obj;
  logic [7:0]  ci, next_ci;
  logic        next_wr_en;
  logic [15:0] next_wr_addr;
  logic [15:0] next_wr_data;
  logic        buf_we;
  logic        rb_we;
  logic [5:0]  rb_wa;
  logic [7:0]  rb_wd;
  logic        f_valid;
  logic [7:0]  f_data;
  logic        f_ready;
  logic [15:0] start;
  logic [15:0] cnt;
  logic [5:0]  wr_idx;
  logic        single;
  logic [7:0]  olen;

  always_comb begin
    next_state   = state;
    next_kind    = kind;
    next_len     = len;
    next_over    = over;
    next_perr    = perr;
    next_gcnt    = (gcnt == GCNT_MAX) ? gcnt : gcnt + 24'h00_0001;
    next_idx     = idx;
    next_crc     = crc;
    next_exc     = exc;
    next_k       = k;
    next_phase   = phase;
    next_rlen    = rlen;
    next_obj     = obj;
    next_ci      = ci;
    next_wr_en   = 1'b0;
    next_wr_addr = o_wr_addr;
    next_wr_data = o_wr_data;
    buf_we       = 1'b0;
    rb_we        = 1'b0;
    rb_wa        = k;
    rb_wd        = 8'h00;
    f_valid      = 1'b0;
    f_data       = 8'h00;
    start        = {rxb[2], rxb[3]};
    cnt          = {rxb[4], rxb[5]};
    wr_idx       = 6'd7 + 6'({k[4:0], 1'b0});
    single       = rxb[3] == RD_SINGLE;
    olen         = obj_len(obj);
    unique case (state)
      ST_RX: begin
        if (i_rx_valid) begin
          next_gcnt = 24'h00_0000;
          if (len < 7'(FRAME_MAX)) begin
            buf_we   = 1'b1;
            next_len = len + 7'd1;
          end else begin
            next_over = 1'b1;
          end
          if (i_rx_parity_err) begin
            next_perr = 1'b1;
          end
        end else if (len != 7'd0 && gcnt >= 24'(GAP_CYC)) begin
          next_state = ST_CRC;
          next_idx   = 7'd0;
          next_crc   = CRC_INIT;
        end
      end
      ST_CRC: begin
        if (over || perr || len < 7'(FRAME_MIN)) begin
          next_state = ST_RX;
          next_len   = 7'd0;
          next_over  = 1'b0;
          next_perr  = 1'b0;
        end else if (idx != len) begin
          next_crc = crc_byte(crc, rxb[idx[5:0]]);
          next_idx = idx + 7'd1;
        end else if (crc == 16'h0000 && rxb[0] == i_station_addr) begin
          next_state = ST_EVAL;
        end else begin
          next_state = ST_RX;
          next_len   = 7'd0;
        end
      end
      ST_EVAL: begin
        next_k     = 6'd0;
        next_phase = 1'b0;
        next_kind  = RK_EXC;
        next_state = ST_HDR;
        if (rxb[1] == FC_WRITE_MULTI) begin
          if (cnt == 16'h0000 || cnt > 16'(WR_MAX_REGS) ||
              rxb[6] != {cnt[6:0], 1'b0} ||
              len != 7'(WR_HDR_LEN) + rxb[6][6:0]) begin
            next_exc = EXC_VALUE;
          end else if (17'(start) + 17'(cnt) > 17'(NUM_REGS)) begin
            next_exc = EXC_ADDR;
          end else begin
            next_state = ST_WCHK;
          end
        end else if (rxb[1] == FC_IDENT) begin
          if (len != 7'(IDENT_LEN) || rxb[2] != MEI_IDENT) begin
            next_exc = EXC_VALUE;
          end else if (rxb[3] != RD_BASIC && !single) begin
            next_exc = EXC_VALUE;
          end else if (rxb[4] > OBJ_LAST) begin
            next_exc = EXC_ADDR;
          end else begin
            next_kind = RK_IDENT;
          end
        end else begin
          next_exc = EXC_FUNC;
        end
      end
      ST_WCHK: begin
        if (k == cnt[5:0]) begin
          next_k     = 6'd0;
          next_state = ST_WR;
        end else if (!phase) begin
          next_wr_addr = start + 16'(k);
          next_wr_data = {rxb[wr_idx], rxb[wr_idx + 6'd1]};
          next_phase   = 1'b1;
        end else begin
          next_phase = 1'b0;
          if (i_wr_reject) begin
            next_exc   = EXC_VALUE;
            next_state = ST_HDR;
            next_k     = 6'd0;
          end else begin
            next_k = k + 6'd1;
          end
        end
      end
      ST_WR: begin
        if (k == cnt[5:0]) begin
          next_kind  = RK_ECHO;
          next_k     = 6'd0;
          next_state = ST_HDR;
        end else begin
          next_wr_addr = start + 16'(k);
          next_wr_data = {rxb[wr_idx], rxb[wr_idx + 6'd1]};
          next_wr_en   = 1'b1;
          next_k       = k + 6'd1;
        end
      end
      ST_HDR: begin
        rb_we     = 1'b1;
        next_k    = k + 6'd1;
        next_rlen = 7'(k) + 7'd1;
        unique case (kind)
          RK_EXC: begin
            rb_wd = (k == 6'd0) ? rxb[0] : (k == 6'd1) ? (rxb[1] | EXC_FLAG) : exc;
            if (k == 6'(EXC_LEN - 1)) begin
              next_state = ST_WAIT;
            end
          end
          RK_ECHO: begin
            rb_wd = rxb[k];
            if (k == 6'(ECHO_LEN - 1)) begin
              next_state = ST_WAIT;
            end
          end
          default: begin
            unique case (k[2:0])
              3'd2:    rb_wd = MEI_IDENT;
              3'd4:    rb_wd = CONFORMITY;
              3'd5:    rb_wd = NO_MORE;
              3'd6:    rb_wd = 8'h00;
              3'd7:    rb_wd = single ? 8'h01 : (OBJ_LAST + 8'h01 - rxb[4]);
              default: rb_wd = rxb[k];
            endcase
            if (k == 6'(IDHDR_LEN - 1)) begin
              next_state = ST_OBJ;
              next_obj   = rxb[4][1:0];
              next_ci    = 8'h00;
            end
          end
        endcase
      end
      ST_OBJ: begin
        rb_we     = 1'b1;
        rb_wa     = rlen[5:0];
        rb_wd     = (ci == 8'h00) ? {6'd0, obj} :
                    (ci == 8'h01) ? olen : obj_chr(obj, ci - 8'h02);
        next_rlen = rlen + 7'd1;
        next_ci   = ci + 8'h01;
        if (ci == olen + 8'h01) begin
          next_ci = 8'h00;
          if (single || obj == OBJ_LAST[1:0]) begin
            next_state = ST_WAIT;
          end else begin
            next_obj = obj + 2'd1;
          end
        end
      end
      ST_WAIT: begin
        if (gcnt >= 24'(RESP_CYC)) begin
          next_state = ST_SEND;
          next_idx   = 7'd0;
          next_crc   = CRC_INIT;
        end
      end
      ST_SEND: begin
        f_valid = 1'b1;
        f_data  = rbuf[idx[5:0]];
        if (f_ready) begin
          next_crc = crc_byte(crc, f_data);
          next_idx = idx + 7'd1;
          if (idx == rlen - 7'd1) begin
            next_state = ST_CRCLO;
          end
        end
      end
      ST_CRCLO: begin
        f_valid = 1'b1;
        f_data  = crc[7:0];
        if (f_ready) begin
          next_state = ST_CRCHI;
        end
      end
      ST_CRCHI: begin
        f_valid = 1'b1;
        f_data  = crc[15:8];
        if (f_ready) begin
          next_state = ST_RX;
          next_len   = 7'd0;
        end
      end
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      state     <= ST_RX;
      kind      <= RK_EXC;
      len       <= 7'd0;
      over      <= 1'b0;
      perr      <= 1'b0;
      gcnt      <= 24'h00_0000;
      idx       <= 7'd0;
      crc       <= CRC_INIT;
      exc       <= 8'h00;
      k         <= 6'd0;
      phase     <= 1'b0;
      rlen      <= 7'd0;
      obj       <= 2'd0;
      ci        <= 8'h00;
      o_wr_en   <= 1'b0;
      o_wr_addr <= 16'h0000;
      o_wr_data <= 16'h0000;
    end else if (i_ce) begin
      state     <= next_state;
      kind      <= next_kind;
      len       <= next_len;
      over      <= next_over;
      perr      <= next_perr;
      gcnt      <= next_gcnt;
      idx       <= next_idx;
      crc       <= next_crc;
      exc       <= next_exc;
      k         <= next_k;
      phase     <= next_phase;
      rlen      <= next_rlen;
      obj       <= next_obj;
      ci        <= next_ci;
      o_wr_en   <= next_wr_en;
      o_wr_addr <= next_wr_addr;
      o_wr_data <= next_wr_data;
      if (buf_we) begin
        rxb[len[5:0]] <= i_rx_data;
      end
      if (rb_we) begin
        rbuf[rb_wa] <= rb_wd;
      end
    end
  end

  rtu_fifo #(
    .W     (8),
    .DEPTH (FIFO_DEPTH)
  ) u_tx_fifo (
    .i_mclk  (i_mclk),
    .i_reset (i_reset),
    .i_ce    (i_ce),
    .i_valid (f_valid),
    .i_data  (f_data),
    .o_ready (f_ready),
    .o_valid (o_tx_valid),
    .o_data  (o_tx_data),
    .i_ready (i_tx_ready)
  );
endmodule : rtu_slave

// File: rtu_slave_assertions.sv
// concurrent checks on the rtu slave ports
`timescale 1ns/10ps
module rtu_slave_assertions
  import rtu_pkg::*;
#(
  parameter int unsigned NUM_REGS = NUM_REGS_DEF,
  parameter int unsigned GAP_CYC  = 20,
  parameter int unsigned RESP_CYC = 40
) (
  // clock and control
  input wire logic        i_mclk,
  input wire logic        i_reset,
  input wire logic        i_ce,
  input wire logic [7:0]  i_station_addr,
  // receive stream
  input wire logic        i_rx_valid,
  input wire logic [7:0]  i_rx_data,
  input wire logic        i_rx_parity_err,
  // transmit stream
  input wire logic        o_tx_valid,
  input wire logic [7:0]  o_tx_data,
  input wire logic        i_tx_ready,
  // write port
  input wire logic        o_wr_en,
  input wire logic [15:0] o_wr_addr,
  input wire logic [15:0] o_wr_data,
  input wire logic        i_wr_reject
);
  int unsigned since_rx;
  int unsigned next_since_rx;
  int unsigned wr_run;
  int unsigned next_wr_run;

  // cycles since last received byte, length of write burst
  always_comb begin
    next_since_rx = since_rx;
    next_wr_run   = o_wr_en ? wr_run + 1 : 0;
    if (i_ce && i_rx_valid) next_since_rx = 0;
    else if (i_ce && since_rx < 1_000_000) next_since_rx = since_rx + 1;
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      since_rx <= 0;
      wr_run   <= 0;
    end else begin
      since_rx <= next_since_rx;
      wr_run   <= next_wr_run;
    end
  end

  a_tx_valid_holds: assert property (
    @(posedge i_mclk) disable iff (i_reset)
    o_tx_valid && !i_tx_ready && i_ce |=> o_tx_valid) else $error("tx valid dropped early");
  a_tx_data_holds: assert property (
    @(posedge i_mclk) disable iff (i_reset)
    o_tx_valid && !i_tx_ready && i_ce |=> $stable(o_tx_data)) else $error("tx data moved early");
  a_reset_quiet: assert property (
    @(posedge i_mclk) i_reset && i_ce |=> !o_tx_valid && !o_wr_en && o_wr_addr == 16'h0000)
    else $error("outputs active after reset");
  a_resp_delay: assert property (
    @(posedge i_mclk) disable iff (i_reset)
    $rose(o_tx_valid) |-> since_rx >= RESP_CYC) else $error("reply started too soon");
  a_wr_consec: assert property (
    @(posedge i_mclk) disable iff (i_reset)
    o_wr_en && $past(o_wr_en) |-> o_wr_addr == $past(o_wr_addr) + 16'h0001)
    else $error("write addresses not consecutive");
  a_wr_in_range: assert property (
    @(posedge i_mclk) disable iff (i_reset)
    o_wr_en |-> 32'(o_wr_addr) < NUM_REGS) else $error("write to missing register");
  a_wr_burst_len: assert property (
    @(posedge i_mclk) disable iff (i_reset)
    o_wr_en |-> wr_run < 32'(WR_MAX_REGS)) else $error("write burst too long");
  a_wr_after_gap: assert property (
    @(posedge i_mclk) disable iff (i_reset)
    o_wr_en |-> since_rx >= GAP_CYC) else $error("write before frame ended");
endmodule : rtu_slave_assertions

bind rtu_slave rtu_slave_assertions #(
  .NUM_REGS(NUM_REGS),
  .GAP_CYC (GAP_CYC),
  .RESP_CYC(RESP_CYC)
) u_rtu_chk (
  .i_mclk(i_mclk), .i_reset(i_reset), .i_ce(i_ce), .i_station_addr(i_station_addr),
  .i_rx_valid(i_rx_valid), .i_rx_data(i_rx_data), .i_rx_parity_err(i_rx_parity_err),
  .o_tx_valid(o_tx_valid), .o_tx_data(o_tx_data), .i_tx_ready(i_tx_ready),
  .o_wr_en(o_wr_en), .o_wr_addr(o_wr_addr), .o_wr_data(o_wr_data),
  .i_wr_reject(i_wr_reject)
);

// File: test_rtu_slave_multiwrite_ident_errors.sv
// self-checking bench for the rtu slave frame interpreter
`timescale 1ns/10ps
module test_rtu_slave_multiwrite_ident_errors;
  import rtu_pkg::*;
  localparam int GAP   = 20;
  localparam int RESP  = 40;
  localparam int LIMIT = 40_000;
  localparam int NROWS = 15;
  typedef struct {
    int          n;
    logic [87:0] req;
    int          kind;
    logic [7:0]  code;
  } rtu_row_t;
  logic        mclk     = 1'b0;
  logic        rst      = 1'b1;
  logic        ce       = 1'b1;
  logic [7:0]  station  = 8'h0F;
  logic        rx_valid;
  logic [7:0]  rx_data;
  logic        rx_perr;
  logic        tx_valid;
  logic [7:0]  tx_data;
  logic        tx_ready;
  logic        wr_en;
  logic [15:0] wr_addr;
  logic [15:0] wr_data;
  logic        wr_reject;
  logic [31:0] wlog [$];
  string       ids [3] = '{"VNDA", "DRV7X", "V2.05"};
  int          n_errors  = 0;
  int          cmp_count = 0;
  int          cycles    = 0;
  rtu_row_t    rows [NROWS] = '{
    '{11, 88'h0F10_0064_0002_0400_0A00_14, 0, 8'h00},
    '{9,  88'h0F10_0005_0001_0212_3400_00, 0, 8'h00},
    '{5,  88'h0F2B_0E01_0000_0000_0000_00, 1, 8'h00},
    '{5,  88'h0F2B_0E01_0200_0000_0000_00, 1, 8'h00},
    '{5,  88'h0F2B_0E04_0100_0000_0000_00, 1, 8'h00},
    '{6,  88'h0F03_0000_0001_0000_0000_00, 2, 8'h01},
    '{11, 88'h0F10_03FF_0002_0400_0100_02, 2, 8'h02},
    '{9,  88'h0F10_0200_0001_0200_0500_00, 2, 8'h03},
    '{7,  88'h0F10_0010_0000_0000_0000_00, 2, 8'h03},
    '{5,  88'h0F2B_0E01_0300_0000_0000_00, 2, 8'h02},
    '{5,  88'h0F2B_0E02_0000_0000_0000_00, 2, 8'h03},
    '{5,  88'h0F2B_0D01_0000_0000_0000_00, 2, 8'h03},
    '{6,  88'h0F2B_0E01_0000_0000_0000_00, 2, 8'h03},
    '{9,  88'h0F10_0005_0001_0312_3400_00, 2, 8'h03},
    '{7,  88'h0F10_0000_001C_3800_0000_00, 2, 8'h03}
  };

  initial forever #10 mclk = ~mclk;

  rtu_slave #(
    .GAP_CYC (GAP),
    .RESP_CYC(RESP),
    .VENDOR  ("VNDA"),
    .PRODUCT ("DRV7X"),
    .REVISION("V2.05")
  ) dut (
    .i_mclk(mclk), .i_reset(rst), .i_ce(ce), .i_station_addr(station),
    .i_rx_valid(rx_valid), .i_rx_data(rx_data), .i_rx_parity_err(rx_perr),
    .o_tx_valid(tx_valid), .o_tx_data(tx_data), .i_tx_ready(tx_ready),
    .o_wr_en(wr_en), .o_wr_addr(wr_addr), .o_wr_data(wr_data), .i_wr_reject(wr_reject)
  );

  rtu_master_model #(.GAP(GAP)) mst (
    .i_mclk(mclk), .o_rx_valid(rx_valid), .o_rx_data(rx_data),
    .o_rx_parity_err(rx_perr), .i_tx_valid(tx_valid), .i_tx_data(tx_data),
    .o_tx_ready(tx_ready)
  );

  // parameter memory: one read-only register
  assign wr_reject = (wr_addr == 16'h0200);
  always @(posedge mclk) if (wr_en === 1'b1) wlog.push_back({wr_addr, wr_data});

  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      n_errors++;
      close_out();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] want);
    cmp_count++;
    if (got !== want) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, want);
      n_errors++;
    end
  endtask : check

  task automatic close_out;
    if (n_errors == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : close_out

  function automatic void ident_exp(input logic [7:0] code, input logic [7:0] obj,
                                    ref logic [7:0] q [$]);
    int last;
    last = (code == 8'h01) ? 2 : int'(obj);
    q = '{8'h0F, 8'h2B, 8'h0E, code, 8'h81, 8'h00, 8'h00, 8'(last - int'(obj) + 1)};
    for (int o = int'(obj); o <= last; o++) begin
      q.push_back(8'(o));
      q.push_back(8'(ids[o].len()));
      for (int i = 0; i < ids[o].len(); i++) q.push_back(ids[o][i]);
    end
  endfunction : ident_exp

  task automatic run_frame(input logic [7:0] req [$], input int perr, input int split,
                           input logic [15:0] cx, input logic [7:0] exp [$],
                           input logic [31:0] wexp [$]);
    logic [15:0] c;
    int          t;
    mst.rxq = {};
    wlog = {};
    mst.send(req, perr, split, cx);
    t = 0;
    while (mst.rxq.size() < exp.size() + 2 && t < 1500) begin
      @(posedge mclk);
      t++;
    end
    repeat (20) @(posedge mclk);
    if (exp.size() > 0) begin
      c = mst.crc16(exp);
      exp.push_back(c[7:0]);
      exp.push_back(c[15:8]);
    end
    check(32'(mst.rxq.size()), 32'(exp.size()));
    foreach (exp[i]) if (i < mst.rxq.size()) check(32'(mst.rxq[i]), 32'(exp[i]));
    check(32'(wlog.size()), 32'(wexp.size()));
    foreach (wexp[i]) if (i < wlog.size()) check(wlog[i], wexp[i]);
  endtask : run_frame

  initial begin
    logic [7:0]  req [$];
    logic [7:0]  exp [$];
    logic [31:0] wexp [$];
    logic [7:0]  base [$];
    logic [7:0]  none8 [$];
    logic [31:0] none32 [$];
    repeat (11) @(posedge mclk);
    @(negedge mclk);
    check(32'(tx_valid), 32'h0000_0000);
    check(32'(wr_en), 32'h0000_0000);
    @(posedge mclk);
    rst <= 1'b0;
    for (int r = 0; r < NROWS; r++) begin
      req = {};
      exp = {};
      wexp = {};
      for (int i = 0; i < rows[r].n; i++) req.push_back(rows[r].req[87 - 8*i -: 8]);
      if (rows[r].kind == 0) begin
        exp = req[0:5];
        for (int k = 0; k < int'({req[4], req[5]}); k++)
          wexp.push_back({16'({req[2], req[3]} + k), req[7 + 2*k], req[8 + 2*k]});
      end else if (rows[r].kind == 1) ident_exp(req[3], req[4], exp);
      else exp = '{req[0], req[1] | 8'h80, rows[r].code};
      run_frame(req, -1, -1, 16'h0000, exp, wexp);
    end
    base = '{8'h0F, 8'h10, 8'h00, 8'h07, 8'h00, 8'h01, 8'h02, 8'hAB, 8'hCD};
    run_frame(base, 3, -1, 16'h0000, none8, none32);
    run_frame(base, -1, -1, 16'h0001, none8, none32);
    run_frame(base, -1, 4, 16'h0000, none8, none32);
    req = base;
    req[0] = 8'h0E;
    run_frame(req, -1, -1, 16'h0000, none8, none32);
    req = '{8'h0F, 8'h10, 8'h00, 8'h00, 8'h00, 8'h1E, 8'h3C};
    for (int i = 0; i < 60; i++) req.push_back(8'(i));
    run_frame(req, -1, -1, 16'h0000, none8, none32);
    wexp = '{32'h0007_ABCD};
    // frozen enable holds the reply back
    fork
      run_frame(base, -1, -1, 16'h0000, base[0:5], wexp);
      begin
        repeat (30) @(posedge mclk);
        ce <= 1'b0;
        repeat (100) @(posedge mclk);
        check(32'(mst.rxq.size()), 32'h0000_0000);
        ce <= 1'b1;
      end
    join
    // slow drain after dropped frames
    mst.stall <= 3;
    run_frame(base, -1, -1, 16'h0000, base[0:5], wexp);
    ident_exp(8'h01, 8'h00, exp);
    run_frame('{8'h0F, 8'h2B, 8'h0E, 8'h01, 8'h00}, -1, -1, 16'h0000, exp, none32);
    mst.stall = 0;
    close_out();
  end
endmodule : test_rtu_slave_multiwrite_ident_errors
